/* File: include/thermal_sensor_pkg.sv */
`default_nettype none
package thermal_sensor_pkg;
  // register pointer values
  localparam logic [2:0] PTR_FEATURE  = 3'h0;
  localparam logic [2:0] PTR_SETUP    = 3'h1;
  localparam logic [2:0] PTR_UPPER    = 3'h2;
  localparam logic [2:0] PTR_LOWER    = 3'h3;
  localparam logic [2:0] PTR_CRITICAL = 3'h4;
  localparam logic [2:0] PTR_MEASURED = 3'h5;
  localparam logic [2:0] PTR_MAKER    = 3'h6;
  localparam logic [2:0] PTR_PART     = 3'h7;

  localparam logic [15:0] FEATURE_SUMMARY_VALUE = 16'h007F;
  // arbitrary identity values
  localparam logic [15:0] MAKER_CODE_VALUE      = 16'h5A5A;
  localparam logic [15:0] PART_REVISION_VALUE   = 16'h0101;

  // sensor_setup field positions
  localparam int SETUP_MODE      = 0;
  localparam int SETUP_POLARITY  = 1;
  localparam int SETUP_CRIT_ONLY = 2;
  localparam int SETUP_ENABLE    = 3;
  localparam int SETUP_STATUS    = 4;
  localparam int SETUP_CLEAR     = 5;
  localparam int SETUP_WIN_LOCK  = 6;
  localparam int SETUP_CRIT_LOCK = 7;
  localparam int SETUP_SHUTDOWN  = 8;
  localparam int SETUP_DEADBAND  = 9;
  localparam int SETUP_WIDTH     = 11;

  // limit registers implement bits 12..2
  localparam int LIMIT_LSB = 2;
  localparam int LIMIT_MSB = 12;
  localparam int READING_WIDTH = 13;

  // deadband in reading units of 1/16 degree
  localparam logic [6:0] DEADBAND_NONE = 7'h00;
  localparam logic [6:0] DEADBAND_1P5  = 7'h18;
  localparam logic [6:0] DEADBAND_3    = 7'h30;
  localparam logic [6:0] DEADBAND_6    = 7'h60;

  // serial slave type nibble, followed by the three address straps
  localparam logic [3:0] SENSOR_TYPE_CODE = 4'h3;

  localparam int SYS_CLK_KHZ        = 50_000;
  localparam int CONV_INTERVAL_MS   = 100;
  localparam int BUS_TIMEOUT_MIN_MS = 25;
  localparam int CONV_CYCLES_DEFAULT = CONV_INTERVAL_MS * SYS_CLK_KHZ;
  localparam int TIMEOUT_CYCLES_DEFAULT = BUS_TIMEOUT_MIN_MS * SYS_CLK_KHZ;

  typedef enum logic [2:0] {
    PH_IDLE, PH_RX, PH_RX_ACK, PH_TX, PH_TX_ACK
  } bus_phase_type;
endpackage
`default_nettype wire

/* File: hw/thermal_sensor_registers.sv */
`timescale 1ns/1ns
`default_nettype none
module thermal_sensor_registers #(
  parameter int CONV_CYCLES    = thermal_sensor_pkg::CONV_CYCLES_DEFAULT,
  parameter int TIMEOUT_CYCLES = thermal_sensor_pkg::TIMEOUT_CYCLES_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [2:0]  addrPins,
  output logic             convStart,
  input  wire logic        convValid,
  input  wire logic [12:0] convData,
  output logic             alertOut,
  output logic             alertOe
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int RW = thermal_sensor_pkg::READING_WIDTH;
  localparam int LW = thermal_sensor_pkg::LIMIT_MSB
                    - thermal_sensor_pkg::LIMIT_LSB + 1;
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
  localparam logic [TW-1:0] TOUT_LAST = TW'(TIMEOUT_CYCLES - 1);

  if (CONV_CYCLES < 2 || TIMEOUT_CYCLES < 2) begin : g_check
    $error("cycle counts must be at least 2");
  end

  typedef struct packed {
    logic [1:0]                         sclPipe;
    logic [1:0]                         sdaPipe;
    logic [5:0]                         addrPipe;
    logic                               sclPrev;
    logic                               sdaPrev;
    thermal_sensor_pkg::bus_phase_type  phase;
    logic [3:0]                         bitCnt;
    logic [1:0]                         byteNo;
    logic [7:0]                         shift;
    logic [7:0]                         msbByte;
    logic [7:0]                         txLow;
    logic                               isRead;
    logic                               lowNext;
    logic                               sdaLow;
    logic [TW-1:0]                      toutCnt;
    logic [2:0]                         ptr;
    logic [10:0]                        setup;
    logic [LW-1:0]                      upper;
    logic [LW-1:0]                      lower;
    logic [LW-1:0]                      crit;
    logic [RW-1:0]                      result;
    logic                               critFlag;
    logic                               highFlag;
    logic                               lowFlag;
    logic                               condPrev;
    logic                               intLatch;
    logic                               alertSts;
    logic                               pinLow;
    logic [CW-1:0]                      convCnt;
    logic                               convPulse;
  } state_type;

  state_type cur;
  state_type next_cur;

  function automatic logic [6:0] deadband(input logic [1:0] sel);
    unique case (sel)
      2'b00: deadband = thermal_sensor_pkg::DEADBAND_NONE;
      2'b01: deadband = thermal_sensor_pkg::DEADBAND_1P5;
      2'b10: deadband = thermal_sensor_pkg::DEADBAND_3;
      2'b11: deadband = thermal_sensor_pkg::DEADBAND_6;
    endcase
  endfunction

  // limit widened to 14-bit signed reading units
  function automatic logic signed [13:0] widen(input logic [LW-1:0] lim);
    widen = {lim[LW-1], lim, 2'b00};
  endfunction

  function automatic logic [15:0] readReg(input state_type s);
    readReg = 16'h0000;
    unique case (s.ptr)
      thermal_sensor_pkg::PTR_FEATURE:
        readReg = thermal_sensor_pkg::FEATURE_SUMMARY_VALUE;
      thermal_sensor_pkg::PTR_SETUP: begin
        readReg[10:0] = s.setup;
        readReg[thermal_sensor_pkg::SETUP_STATUS] = s.alertSts;
        readReg[thermal_sensor_pkg::SETUP_CLEAR]  = 1'b0;
      end
      thermal_sensor_pkg::PTR_UPPER:
        readReg[12:2] = s.upper;
      thermal_sensor_pkg::PTR_LOWER:
        readReg[12:2] = s.lower;
      thermal_sensor_pkg::PTR_CRITICAL:
        readReg[12:2] = s.crit;
      thermal_sensor_pkg::PTR_MEASURED:
        readReg = {s.critFlag, s.highFlag, s.lowFlag, s.result};
      thermal_sensor_pkg::PTR_MAKER:
        readReg = thermal_sensor_pkg::MAKER_CODE_VALUE;
      thermal_sensor_pkg::PTR_PART:
        readReg = thermal_sensor_pkg::PART_REVISION_VALUE;
    endcase
  endfunction

  logic                 scl;
  logic                 sda;
  logic                 sclRise;
  logic                 sclFall;
  logic                 startSeen;
  logic                 stopSeen;
  logic                 winLock;
  logic                 critLock;
  logic                 anyLock;
  logic                 shutdown;
  logic                 intMode;
  logic signed [13:0]   temp;
  logic signed [13:0]   band;
  logic                 nCrit;
  logic                 nHigh;
  logic                 nLow;
  logic                 cond;
  logic [15:0]          wdata;
  logic [15:0]          word;

  always_comb begin
    scl       = cur.sclPipe[1];
    sda       = cur.sdaPipe[1];
    sclRise   = scl & ~cur.sclPrev;
    sclFall   = ~scl & cur.sclPrev;
    startSeen = scl & cur.sclPrev & cur.sdaPrev & ~sda;
    stopSeen  = scl & cur.sclPrev & ~cur.sdaPrev & sda;
    winLock   = cur.setup[thermal_sensor_pkg::SETUP_WIN_LOCK];
    critLock  = cur.setup[thermal_sensor_pkg::SETUP_CRIT_LOCK];
    anyLock   = winLock | critLock;
    shutdown  = cur.setup[thermal_sensor_pkg::SETUP_SHUTDOWN];
    intMode   = cur.setup[thermal_sensor_pkg::SETUP_MODE];
    temp      = {cur.result[RW-1], cur.result};
    band      = {7'h00, deadband(cur.setup[10:9])};
    // deadband only delays the release of a flag
    nCrit = (temp >= widen(cur.crit))
          | (cur.critFlag & (temp >= widen(cur.crit) - band));
    nHigh = (temp > widen(cur.upper))
          | (cur.highFlag & (temp > widen(cur.upper) - band));
    nLow  = (temp < widen(cur.lower))
          | (cur.lowFlag & (temp < widen(cur.lower) + band));
    cond  = cur.setup[thermal_sensor_pkg::SETUP_CRIT_ONLY]
          ? nCrit : (nCrit | nHigh | nLow);
    wdata = {cur.msbByte, cur.shift};
    word  = readReg(cur);
  end

  always_comb begin
    next_cur = cur;
    next_cur.sclPipe  = {cur.sclPipe[0], sclIn};
    next_cur.sdaPipe  = {cur.sdaPipe[0], sdaIn};
    next_cur.addrPipe = {cur.addrPipe[2:0], addrPins};
    next_cur.sclPrev  = scl;
    next_cur.sdaPrev  = sda;
    next_cur.convPulse = 1'b0;

    // conversion pacing; register reads never touch it
    if (shutdown) begin
      next_cur.convCnt = '0;
    end else begin
      next_cur.convPulse = (cur.convCnt == '0);
      next_cur.convCnt = (cur.convCnt == CONV_LAST)
                       ? '0 : cur.convCnt + 1'b1;
      if (convValid) begin
        next_cur.result = convData;
      end
    end

    next_cur.critFlag = nCrit;
    next_cur.highFlag = nHigh;
    next_cur.lowFlag  = nLow;

    // stalled-clock watchdog lets a hung master not hold sda
    if (cur.phase != thermal_sensor_pkg::PH_IDLE && !scl) begin
      next_cur.toutCnt = cur.toutCnt + 1'b1;
    end else begin
      next_cur.toutCnt = '0;
    end

    if (startSeen) begin
      next_cur.phase  = thermal_sensor_pkg::PH_RX;
      next_cur.bitCnt = '0;
      next_cur.byteNo = 2'd0;
      next_cur.sdaLow = 1'b0;
    end else if (stopSeen || cur.toutCnt == TOUT_LAST) begin
      next_cur.phase  = thermal_sensor_pkg::PH_IDLE;
      next_cur.sdaLow = 1'b0;
    end else begin
      unique case (cur.phase)
        thermal_sensor_pkg::PH_IDLE: ;
        thermal_sensor_pkg::PH_RX: begin
          if (sclRise) begin
            next_cur.shift  = {cur.shift[6:0], sda};
            next_cur.bitCnt = cur.bitCnt + 1'b1;
          end else if (sclFall && cur.bitCnt == 4'd8) begin
            next_cur.bitCnt = '0;
            next_cur.phase  = thermal_sensor_pkg::PH_RX_ACK;
            next_cur.sdaLow = 1'b1;
            unique case (cur.byteNo)
              2'd0: begin
                if (cur.shift[7:1] != {thermal_sensor_pkg::SENSOR_TYPE_CODE,
                                       cur.addrPipe[5:3]}) begin
                  next_cur.phase  = thermal_sensor_pkg::PH_IDLE;
                  next_cur.sdaLow = 1'b0;
                end
                next_cur.isRead  = cur.shift[0];
                next_cur.lowNext = 1'b0;
              end
              2'd1: next_cur.ptr = cur.shift[2:0];
              2'd2: next_cur.msbByte = cur.shift;
              2'd3: begin
                unique case (cur.ptr)
                  thermal_sensor_pkg::PTR_SETUP: begin
                    if (!anyLock) begin
                      next_cur.setup[10:9] = wdata[10:9];
                      next_cur.setup[3]    = wdata[3];
                      next_cur.setup[1:0]  = wdata[1:0];
                      next_cur.setup[8]    = wdata[8];
                    end else begin
                      next_cur.setup[8] = cur.setup[8] & wdata[8];
                    end
                    next_cur.setup[2] = winLock
                                      ? (cur.setup[2] & wdata[2])
                                      : wdata[2];
                    next_cur.setup[7:6] = cur.setup[7:6]
                                        | wdata[7:6];
                    if (wdata[thermal_sensor_pkg::SETUP_CLEAR]) begin
                      if (intMode && !nCrit) begin
                        next_cur.intLatch = 1'b0;
                      end
                      if (shutdown) begin
                        next_cur.alertSts = 1'b0;
                      end
                    end
                  end
                  thermal_sensor_pkg::PTR_UPPER:
                    if (!winLock) next_cur.upper = wdata[12:2];
                  thermal_sensor_pkg::PTR_LOWER:
                    if (!winLock) next_cur.lower = wdata[12:2];
                  thermal_sensor_pkg::PTR_CRITICAL:
                    if (!critLock) next_cur.crit = wdata[12:2];
                  default: ;
                endcase
              end
            endcase
          end
        end
        thermal_sensor_pkg::PH_RX_ACK: begin
          if (sclFall) begin
            next_cur.sdaLow = 1'b0;
            if (cur.isRead) begin
              // word caught at the high byte so both halves agree
              next_cur.phase   = thermal_sensor_pkg::PH_TX;
              next_cur.lowNext = ~cur.lowNext;
              next_cur.shift   = cur.lowNext ? cur.txLow : word[15:8];
              if (!cur.lowNext) next_cur.txLow = word[7:0];
              next_cur.sdaLow  = cur.lowNext ? ~cur.txLow[7] : ~word[15];
            end else begin
              next_cur.phase  = thermal_sensor_pkg::PH_RX;
              next_cur.byteNo = (cur.byteNo == 2'd3) ? 2'd2
                              : cur.byteNo + 2'd1;
            end
          end
        end
        thermal_sensor_pkg::PH_TX: begin
          if (sclRise) begin
            next_cur.bitCnt = cur.bitCnt + 1'b1;
          end else if (sclFall) begin
            if (cur.bitCnt == 4'd8) begin
              next_cur.bitCnt = '0;
              next_cur.sdaLow = 1'b0;
              next_cur.phase  = thermal_sensor_pkg::PH_TX_ACK;
            end else begin
              next_cur.shift  = {cur.shift[6:0], 1'b0};
              next_cur.sdaLow = ~cur.shift[6];
            end
          end
        end
        thermal_sensor_pkg::PH_TX_ACK: begin
          if (sclRise) begin
            next_cur.phase = sda ? thermal_sensor_pkg::PH_IDLE
                                 : thermal_sensor_pkg::PH_RX_ACK;
          end
        end
      endcase
    end

    // alert path; frozen while shut down, where only a clear write changes it (drops alertSts)
    if (!shutdown) begin
      next_cur.condPrev = cond;
      if (!intMode) begin
        next_cur.intLatch = 1'b0;
      end else if (cond && !cur.condPrev) begin
        next_cur.intLatch = 1'b1;
      end
      next_cur.alertSts = cur.setup[thermal_sensor_pkg::SETUP_ENABLE]
                        & (intMode ? (cur.intLatch | nCrit)
                                   : cond);
    end
    // polarity low pulls the pin when asserted; high pulls it when idle
    next_cur.pinLow = cur.setup[thermal_sensor_pkg::SETUP_POLARITY]
                    ? ~next_cur.alertSts : next_cur.alertSts;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sdaOut    = 1'b0;
  assign sdaOe     = cur.sdaLow;
  assign alertOut  = 1'b0;
  assign alertOe   = cur.pinLow;
  assign convStart = cur.convPulse;
endmodule
`default_nettype wire

/* File: verif/thermal_sensor_props.sv */
`timescale 1ns/1ns
`default_nettype none
module thermal_sensor_props #(
  parameter int CONV_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic convStart,
  input wire logic alertOut,
  input wire logic alertOe
);
  // first request after reset has no predecessor, so it is not spaced
  logic [31:0] gap;
  logic        seen;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gap  <= 32'h0;
      seen <= 1'b0;
    end else begin
      gap  <= convStart ? 32'h0 : gap + 32'h1;
      seen <= seen | convStart;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_conv_pulse: assert property (
    convStart |=> !convStart) else $error("conversion request too wide");
  a_conv_boot: assert property (
    $fell(reset) |-> ##[0:2] convStart) else $error("no first conversion");
  a_conv_spacing: assert property (
    convStart && seen |-> gap >= 32'(CONV_CYCLES - 1))
    else $error("conversion restarted early");
  a_alert_boot: assert property (
    $fell(reset) |-> !alertOe [*8]) else $error("alert active after reset");
  a_sda_drain: assert property (
    !sdaOut) else $error("data pin driven high");
  a_alert_drain: assert property (
    !alertOut) else $error("alert pin driven high");
  a_ack_scl_low: assert property (
    $rose(sdaOe) |-> !sclIn) else $error("data pulled while clock high");
  a_release_low: assert property (
    $fell(sdaOe) |-> !sclIn) else $error("data released while clock high");
  a_ack_holds: assert property (
    $rose(sdaOe) |-> sdaOe until_with $fell(sclIn))
    else $error("data pull dropped early");
  a_ack_bounded: assert property (
    $rose(sdaOe) |-> ##[1:12] $fell(sclIn)) else $error("pull not clocked");
  c_conv: cover property (convStart);
  c_ack: cover property ($rose(sdaOe));
  c_alert: cover property ($rose(alertOe));
endmodule
`default_nettype wire

/* File: verif/i2c_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  input  wire logic       sys_clk,
  input  wire logic       sdaLevel,
  input  wire logic [2:0] straps,
  output var logic        scl,
  output var logic        hostLow,
  output var logic        rdDone,
  output var logic [15:0] rdData
);
  initial begin
    scl = 1'b1;
    hostLow = 1'b0;
    rdDone = 1'b0;
    rdData = 16'h0000;
  end
  // 160 ns bit: data moves mid-low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    repeat (2) @(negedge sys_clk);
    hostLow = ~b;
    repeat (2) @(negedge sys_clk);
    scl = 1'b1;
    repeat (3) @(negedge sys_clk);
    s = sdaLevel;
    @(negedge sys_clk);
  endtask
  task automatic start();
    logic s;
    bit_io(1'b1, s);
    hostLow = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic stop();
    logic s;
    bit_io(1'b0, s);
    hostLow = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // holds the clock low mid-transfer to provoke the bus watchdog
  task automatic stall(input int n);
    scl = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic send(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ok = ok & ~s;
  endtask
  task automatic recv(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~more, s);
  endtask
  task automatic write_reg(input logic [2:0] p, input logic [15:0] d,
                           input logic bad, output logic ok);
    ok = 1'b1;
    start();
    send({thermal_sensor_pkg::SENSOR_TYPE_CODE, straps ^ {bad, 2'h0}, 1'b0}, ok);
    send({5'h00, p}, ok);
    send(d[15:8], ok);
    send(d[7:0], ok);
    stop();
  endtask
  task automatic read_reg(input logic [2:0] p, input logic setPtr);
    logic ok;
    ok = 1'b1;
    if (setPtr) begin
      start();
      send({thermal_sensor_pkg::SENSOR_TYPE_CODE, straps, 1'b0}, ok);
      send({5'h00, p}, ok);
    end
    start();
    send({thermal_sensor_pkg::SENSOR_TYPE_CODE, straps, 1'b1}, ok);
    recv(1'b1, rdData[15:8]);
    recv(1'b0, rdData[7:0]);
    stop();
    rdDone = 1'b1;
    @(negedge sys_clk);
    rdDone = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/thermal_sensor_registers_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module thermal_sensor_registers_bench;
  localparam int CONV = 50;
  logic        sys_clk, reset, scl, hostLow, rdDone, ok;
  logic        sdaOut, sdaOe, convStart, convValid, convMute;
  logic        alertOut, alertOe;
  logic [2:0]  straps;
  logic [12:0] convData, temp, up, lo, cr;
  logic [15:0] rdData, held;
  logic [15:0] expQ[$];
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  wire logic   sda = ~(hostLow | sdaOe);
  thermal_sensor_registers #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(200))
    thermal_sensor_registers_i (
    .sys_clk(sys_clk), .reset(reset), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrPins(straps),
    .convStart(convStart), .convValid(convValid), .convData(convData),
    .alertOut(alertOut), .alertOe(alertOe));
  i2c_host_model i2c_host_model_i (
    .sys_clk(sys_clk), .sdaLevel(sda), .straps(straps), .scl(scl),
    .hostLow(hostLow), .rdDone(rdDone), .rdData(rdData));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // converter stand-in; data bus churns between conversion requests
  always @(negedge sys_clk) begin
    convValid <= convStart & ~convMute;
    convData  <= convStart ? temp : convData ^ 13'h1555;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      wrap_up();
    end
    if (rdDone === 1'b1) compare16(rdData, expQ.pop_front());
  end
  task automatic compare16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic compare_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    i2c_host_model_i.write_reg(p, d, 1'b0, ok);
    compare_bit(ok, 1'b1);
  endtask
  task automatic rd(input logic [2:0] p, input logic [15:0] e);
    expQ.push_back(e);
    i2c_host_model_i.read_reg(p, 1'b1);
  endtask
  task automatic lims(input logic [12:0] u, l, c);
    {up, lo, cr} = {u, l, c};
    wr(3'h2, {3'h0, u});
    wr(3'h3, {3'h0, l});
    wr(3'h4, {3'h0, c});
  endtask
  task automatic settle();
    repeat (3 * CONV) @(negedge sys_clk);
  endtask
  function automatic logic [12:0] rl();
    return 13'($urandom()) & 13'h1FFC;
  endfunction
  function automatic logic [15:0] res(input logic [12:0] t);
    return {$signed(t) >= $signed(cr), $signed(t) > $signed(up),
            $signed(t) < $signed(lo), t};
  endfunction
  initial begin
    {reset, convMute, temp, up, lo, cr} = {2'h2, 52'h0};
    straps = 3'($urandom(99));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    compare_bit(alertOe, 1'b0);
    expQ.push_back(16'h007F);
    i2c_host_model_i.read_reg(3'h0, 1'b0);
    for (int p = 1; p < 5; p++) rd(3'(p), 16'h0000);
    rd(3'h5, 16'h8000);
    rd(3'h6, thermal_sensor_pkg::MAKER_CODE_VALUE);
    rd(3'h7, thermal_sensor_pkg::PART_REVISION_VALUE);
    wr(3'h0, 16'hFFFF);
    rd(3'h0, 16'h007F);
    for (int i = 0; i < 6; i++) begin
      temp = rl();
      if (i == 0) lims(temp, temp, temp);
      else begin
        lims(rl(), rl(), rl());
        temp = 13'($urandom());
      end
      settle();
      rd(3'h5, res(temp));
      rd(3'h2, {3'h0, up});
    end
    held = res(temp);
    wr(3'h1, 16'h0100);
    temp = ~temp;
    settle();
    rd(3'h5, held);
    wr(3'h1, 16'h0000);
    settle();
    rd(3'h5, res(temp));
    lims(13'h0200, 13'h0100, 13'h0400);
    temp = 13'h0180;
    wr(3'h1, 16'h0008);
    settle();
    compare_bit(alertOe, 1'b0);
    temp = 13'h0280;
    settle();
    compare_bit(alertOe, 1'b1);
    rd(3'h1, 16'h0018);
    temp = 13'h0180;
    settle();
    compare_bit(alertOe, 1'b0);
    wr(3'h1, 16'h000A);
    compare_bit(alertOe, 1'b1);
    wr(3'h1, 16'h0008);
    convMute = 1'b1;
    wr(3'h2, 16'h0100);
    compare_bit(alertOe, 1'b1);
    wr(3'h2, 16'h0200);
    convMute = 1'b0;
    wr(3'h1, 16'h0009);
    temp = 13'h0280;
    settle();
    temp = 13'h0180;
    settle();
    compare_bit(alertOe, 1'b1);
    wr(3'h1, 16'h0029);
    compare_bit(alertOe, 1'b0);
    rd(3'h1, 16'h0009);
    temp = 13'h0480;
    settle();
    wr(3'h1, 16'h0029);
    compare_bit(alertOe, 1'b1);
    wr(3'h1, 16'h0109);
    temp = 13'h0180;
    settle();
    compare_bit(alertOe, 1'b1);
    wr(3'h1, 16'h0129);
    compare_bit(alertOe, 1'b0);
    wr(3'h2, 16'h0100);
    compare_bit(alertOe, 1'b0);
    wr(3'h2, 16'h0200);
    wr(3'h1, 16'h0000);
    settle();
    wr(3'h1, 16'h0208);
    temp = 13'h0210;
    settle();
    compare_bit(alertOe, 1'b1);
    temp = 13'h01F0;
    settle();
    compare_bit(alertOe, 1'b1);
    temp = 13'h01E0;
    settle();
    compare_bit(alertOe, 1'b0);
    wr(3'h1, 16'h0000);
    // a long clock stall mid-address must drop the slave back to idle
    held = {8'h00, thermal_sensor_pkg::SENSOR_TYPE_CODE, straps, 1'b0};
    i2c_host_model_i.start();
    for (int b = 7; b >= 0; b--) begin
      if (b == 3) i2c_host_model_i.stall(220);
      i2c_host_model_i.bit_io(held[b], ok);
    end
    i2c_host_model_i.bit_io(1'b1, ok);
    compare_bit(ok, 1'b1);
    i2c_host_model_i.stop();
    i2c_host_model_i.write_reg(3'h2, 16'h1000, 1'b1, ok);
    compare_bit(ok, 1'b0);
    wr(3'h1, 16'h00C0);
    wr(3'h2, 16'h1000);
    wr(3'h4, 16'h1000);
    wr(3'h1, 16'h0000);
    rd(3'h2, 16'h0200);
    rd(3'h4, 16'h0400);
    rd(3'h1, 16'h00C0);
    wrap_up();
  end
endmodule
bind thermal_sensor_registers thermal_sensor_props #(
  .CONV_CYCLES(CONV_CYCLES)) thermal_sensor_props_i (
  .sys_clk(sys_clk), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .convStart(convStart), .alertOut(alertOut),
  .alertOe(alertOe));
`default_nettype wire
